// ===== logic/aesrt_map.vh
`ifndef AESRT_MAP_VH
`define AESRT_MAP_VH

// ****************************************************************
// Datapath geometry
// ****************************************************************
`define AESRT_STATE_W     128
`define AESRT_BYTE_W      8
`define AESRT_NUM_BYTES   16
`define AESRT_NUM_COLS    4
`define AESRT_NUM_ENTRIES 2
`define AESRT_ADDR_W      32

// ****************************************************************
// Command codes on CMD_OP
// ****************************************************************
`define AESRT_OP_W        3
`define AESRT_OP_LOAD     3'h0
`define AESRT_OP_SUBBYTES 3'h1
`define AESRT_OP_ROUNDKEY 3'h2
`define AESRT_OP_MIXCOL   3'h3
`define AESRT_OP_SETPTR   3'h4
`define AESRT_OP_MOVE     3'h5

// ****************************************************************
// Arithmetic constants
// ****************************************************************
`define AESRT_PTR_STEP    32'h00000010
`define AESRT_ALIGN_MASK  32'h0000000f
`define AESRT_GF_POLY     8'h1b
`define AESRT_AFFINE_C    8'h63
`define AESRT_INV_EXP     8'hfe
`define AESRT_RESET_PTR   32'h00000000
`define AESRT_RESET_STATE 128'h0

`endif

// ===== logic/aesrt_sbox.v
`timescale 1ns/1ps
`default_nettype none
`include "aesrt_map.vh"

// ****************************************************************
// Byte substitution: fixed constant function, no storage
// ****************************************************************
module aesrt_sbox
(
  // Byte in
  input  wire [7:0] din,
  // Substituted byte out
  output wire [7:0] dout
);

  function [7:0] gf_mul;
    input [7:0] a;
    input [7:0] b;
    reg   [7:0] acc;
    reg   [7:0] p;
    integer     k;
    begin
      acc = 8'h00;
      p = a;
      for (k = 0; k < 8; k = k + 1)
      begin
        if (b[k])
          acc = acc ^ p;
        p = p[7] ? ({p[6:0], 1'b0} ^ `AESRT_GF_POLY) : {p[6:0], 1'b0};
      end
      gf_mul = acc;
    end
  endfunction

  // Inverse as a^254; zero maps to zero as the cipher demands
  function [7:0] gf_inv;
    input [7:0] a;
    reg   [7:0] res;
    reg   [7:0] pw;
    reg   [7:0] e;
    integer     k;
    begin
      res = 8'h01;
      pw = a;
      e = `AESRT_INV_EXP;
      for (k = 0; k < 8; k = k + 1)
      begin
        if (e[k])
          res = gf_mul(res, pw);
        pw = gf_mul(pw, pw);
      end
      gf_inv = res;
    end
  endfunction

  wire [7:0] inv = gf_inv(din);

  // Computed rather than listed: same 256 entries, 63 7c 77 first
  assign dout = inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]}
              ^ {inv[4:0], inv[7:5]} ^ {inv[3:0], inv[7:4]}
              ^ `AESRT_AFFINE_C;

endmodule
`default_nettype wire

// ===== logic/aesrt_mixcol.v
`timescale 1ns/1ps
`default_nettype none
`include "aesrt_map.vh"

// ****************************************************************
// One column of the mixing transform
// ****************************************************************
module aesrt_mixcol
(
  // Column in, byte 0 in bits 31:24
  input  wire [31:0] col_in,
  // Column out, same order
  output wire [31:0] col_out
);

  function [7:0] gf_double;
    input [7:0] b;
    begin
      gf_double = b[7] ? ({b[6:0], 1'b0} ^ `AESRT_GF_POLY)
                       : {b[6:0], 1'b0};
    end
  endfunction

  wire [7:0] b0 = col_in[31:24];
  wire [7:0] b1 = col_in[23:16];
  wire [7:0] b2 = col_in[15:8];
  wire [7:0] b3 = col_in[7:0];

  wire [7:0] d0 = gf_double(b0);
  wire [7:0] d1 = gf_double(b1);
  wire [7:0] d2 = gf_double(b2);
  wire [7:0] d3 = gf_double(b3);

  // Times three is double plus self; times one passes through
  wire [7:0] t0 = d0 ^ b0;
  wire [7:0] t1 = d1 ^ b1;
  wire [7:0] t2 = d2 ^ b2;
  wire [7:0] t3 = d3 ^ b3;

  assign col_out = {d0 ^ t1 ^ b2 ^ b3,
                    b0 ^ d1 ^ t2 ^ b3,
                    b0 ^ b1 ^ d2 ^ t3,
                    t0 ^ b1 ^ b2 ^ d3};

endmodule
`default_nettype wire

// ===== logic/aesrt_top.v
`timescale 1ns/1ps
`default_nettype none
`include "aesrt_map.vh"

// Behaviour
// - Substitution replaces each state byte with fixed 256-entry table value, starting 63,7c,77.
// - Substitution table is constant logic, needs no memory access.
// - All sixteen substitutions happen at once; result returns to source entry.
// - Byte i sits at bits 127-8i..120-8i; byte 0 most significant.
// - Round-key drives load address from pointer, XORs returned word into state.
// - Round-key adds sixteen to the pointer after fetching the key.
// - Mixing multiplies each four-byte column by circulant 2 3 1 1 matrix.
// - Doubling shifts left, XORs 1b when top bit was set.
// - Tripling XORs byte with its double; times one passes through.
// - Whole mixing of four columns completes in one cycle, written back.
// - Products may alternatively come from constant tables; computed here instead.
// - State lives in a two-entry register file of 128-bit entries.
module aesrt_top
(
  // Clock and reset
  input  wire         CLK_SYS,
  input  wire         RST_B,
  // Command port
  input  wire         CMD_VALID,
  output wire         CMD_READY,
  input  wire [2:0]   CMD_OP,
  input  wire         CMD_SEL,
  input  wire [127:0] CMD_DATA,
  output reg          DONE,
  // Load path for the round key
  output wire         LOAD_REQ,
  output wire [31:0]  LOAD_VIRTUAL_ADDRESS,
  input  wire [127:0] LOAD_DATA_IN,
  input  wire         LOAD_VALID,
  // State visibility
  output wire [127:0] STATE0,
  output wire [127:0] STATE1,
  output wire [31:0]  POINTER,
  output wire         MISALIGNED
);

  // ****************************************************************
  // Control states
  // ****************************************************************
  localparam [1:0] ST_IDLE  = 2'h1;
  localparam [1:0] ST_FETCH = 2'h2;

  reg  [1:0]   fsm_r;
  reg  [1:0]   fsm_nxt;
  reg          sel_r;
  reg  [31:0]  ptr_r;
  reg  [31:0]  ptr_nxt;
  reg  [127:0] st_r [0:`AESRT_NUM_ENTRIES-1];
  reg  [127:0] wr_data;
  reg          wr_en;
  reg          wr_sel;
  reg          done_nxt;

  wire         accept = CMD_VALID & fsm_r[0];
  wire [127:0] cur = st_r[CMD_SEL];
  wire [127:0] sub_res;
  wire [127:0] mix_res;
  wire [127:0] rk_res = st_r[sel_r] ^ LOAD_DATA_IN;

  assign CMD_READY = fsm_r[0];
  assign LOAD_REQ = fsm_r[1];
  assign LOAD_VIRTUAL_ADDRESS = ptr_r;
  assign STATE0 = st_r[0];
  assign STATE1 = st_r[1];
  assign POINTER = ptr_r;
  // Flag only; the fetch still goes out, placement is the host's duty
  assign MISALIGNED = |(ptr_r & `AESRT_ALIGN_MASK);

  // ****************************************************************
  // Parallel transforms
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `AESRT_NUM_BYTES; g = g + 1)
    begin : gen_sub
      aesrt_sbox u_sbox
      (
        .din  (cur[127-8*g -: 8]),
        .dout (sub_res[127-8*g -: 8])
      );
    end
    for (g = 0; g < `AESRT_NUM_COLS; g = g + 1)
    begin : gen_mix
      aesrt_mixcol u_mix
      (
        .col_in  (cur[127-32*g -: 32]),
        .col_out (mix_res[127-32*g -: 32])
      );
    end
  endgenerate

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always @*
  begin
    fsm_nxt = fsm_r;
    ptr_nxt = ptr_r;
    wr_data = cur;
    wr_en = 1'b0;
    wr_sel = CMD_SEL;
    done_nxt = 1'b0;
    case (fsm_r)
      ST_IDLE:
      begin
        if (accept)
        begin
          case (CMD_OP)
            `AESRT_OP_LOAD:
            begin
              wr_en = 1'b1;
              wr_data = CMD_DATA;
              done_nxt = 1'b1;
            end
            `AESRT_OP_SUBBYTES:
            begin
              wr_en = 1'b1;
              wr_data = sub_res;
              done_nxt = 1'b1;
            end
            `AESRT_OP_MIXCOL:
            begin
              wr_en = 1'b1;
              wr_data = mix_res;
              done_nxt = 1'b1;
            end
            `AESRT_OP_ROUNDKEY:
              fsm_nxt = ST_FETCH;
            `AESRT_OP_SETPTR:
            begin
              ptr_nxt = CMD_DATA[31:0];
              done_nxt = 1'b1;
            end
            `AESRT_OP_MOVE:
            begin
              wr_en = 1'b1;
              wr_sel = ~CMD_SEL;
              wr_data = cur;
              done_nxt = 1'b1;
            end
            default:
              done_nxt = 1'b1;
          endcase
        end
      end
      ST_FETCH:
      begin
        wr_sel = sel_r;
        wr_data = rk_res;
        // Nothing touches state until the key word arrives
        if (LOAD_VALID)
        begin
          wr_en = 1'b1;
          ptr_nxt = ptr_r + `AESRT_PTR_STEP;
          done_nxt = 1'b1;
          fsm_nxt = ST_IDLE;
        end
      end
      default:
        fsm_nxt = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      fsm_r <= ST_IDLE;
      sel_r <= 1'b0;
      ptr_r <= `AESRT_RESET_PTR;
      DONE <= 1'b0;
      st_r[0] <= `AESRT_RESET_STATE;
      st_r[1] <= `AESRT_RESET_STATE;
    end
    else
    begin
      fsm_r <= fsm_nxt;
      ptr_r <= ptr_nxt;
      DONE <= done_nxt;
      if (accept)
        sel_r <= CMD_SEL;
      if (wr_en)
        st_r[wr_sel] <= wr_data;
    end
  end

endmodule
`default_nettype wire

// ===== dv/aesrt_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "aesrt_map.vh"

// ****************************************************************
// Command and load path timing
// ****************************************************************
module aesrt_top_sva
(
  // Clock and reset
  input wire logic         CLK_SYS,
  input wire logic         RST_B,
  // Command port
  input wire logic         CMD_VALID,
  input wire logic         CMD_READY,
  input wire logic [2:0]   CMD_OP,
  input wire logic         DONE,
  // Load path
  input wire logic         LOAD_REQ,
  input wire logic [31:0]  LOAD_VIRTUAL_ADDRESS,
  input wire logic [127:0] LOAD_DATA_IN,
  input wire logic         LOAD_VALID,
  // State
  input wire logic [127:0] STATE0,
  input wire logic [127:0] STATE1,
  input wire logic [31:0]  POINTER,
  input wire logic         MISALIGNED
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  wire take = CMD_VALID && CMD_READY;
  wire got  = LOAD_REQ && LOAD_VALID;

  a_addr_ptr: assert property (LOAD_REQ |-> LOAD_VIRTUAL_ADDRESS == POINTER)
    else $error("load address differs from pointer");
  a_rk_start: assert property (take && CMD_OP == `AESRT_OP_ROUNDKEY |=> LOAD_REQ)
    else $error("round key fetch not started");
  a_key_xor: assert property (got |=> (STATE0 ^ STATE1) == $past(STATE0 ^ STATE1 ^ LOAD_DATA_IN))
    else $error("key not xored into state");
  a_ptr_step: assert property (got |=> POINTER == $past(POINTER) + 32'h10)
    else $error("pointer not advanced by sixteen");
  a_ptr_quiet: assert property (!got && !(take && CMD_OP == `AESRT_OP_SETPTR) |=> $stable(POINTER))
    else $error("pointer changed without cause");
  a_req_hold: assert property (LOAD_REQ && !LOAD_VALID |=> LOAD_REQ && $stable(LOAD_VIRTUAL_ADDRESS))
    else $error("fetch request dropped early");
  a_no_partial: assert property (LOAD_REQ && !LOAD_VALID |=> $stable(STATE0) && $stable(STATE1))
    else $error("state changed before key arrived");
  a_key_done: assert property (got |=> DONE && !LOAD_REQ && CMD_READY)
    else $error("round key did not complete");
  a_busy_fetch: assert property (LOAD_REQ |-> !CMD_READY)
    else $error("ready while fetching");
  a_one_cycle: assert property (take && CMD_OP != `AESRT_OP_ROUNDKEY |=> DONE && CMD_READY)
    else $error("single cycle op took longer");
  a_flag_align: assert property (MISALIGNED == (POINTER[3:0] != 4'h0))
    else $error("alignment flag wrong");

  c_sub: cover property (take && CMD_OP == `AESRT_OP_SUBBYTES);
  c_mix: cover property (take && CMD_OP == `AESRT_OP_MIXCOL);
  c_slow: cover property (LOAD_REQ && !LOAD_VALID ##1 got);
  c_fast: cover property ($rose(LOAD_REQ) && LOAD_VALID);
endmodule

bind aesrt_top aesrt_top_sva i_aesrt_top_sva
(
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
  .CMD_OP(CMD_OP), .DONE(DONE), .LOAD_REQ(LOAD_REQ),
  .LOAD_VIRTUAL_ADDRESS(LOAD_VIRTUAL_ADDRESS), .LOAD_DATA_IN(LOAD_DATA_IN),
  .LOAD_VALID(LOAD_VALID), .STATE0(STATE0), .STATE1(STATE1), .POINTER(POINTER),
  .MISALIGNED(MISALIGNED)
);
`default_nettype wire

// ===== dv/aesrt_load_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Far-side load path, answers after dly request cycles
// ****************************************************************
module aesrt_load_model
(
  // Clock
  input  wire logic         clk,
  // Request from the block
  input  wire logic         load_req,
  input  wire logic [31:0]  addr,
  input  wire logic [3:0]   dly,
  // Answer
  output wire logic         valid,
  output wire logic [127:0] data
);
  reg  [3:0]   cnt_r  = 4'h0;
  reg  [127:0] last_r = 128'h0;
  wire [127:0] key    = {addr, ~addr, addr ^ 32'h5a5a5a5a, addr + 32'h1};

  // Zero delay answers in the cycle the request rises
  assign valid = load_req && (cnt_r >= dly);
  // Idle bus shows the inverse, so a stale word never looks valid
  assign data = valid ? key : ~last_r;

  always @(posedge clk)
  begin
    cnt_r <= load_req ? cnt_r + 4'h1 : 4'h0;
    if (valid)
      last_r <= key;
  end
endmodule
`default_nettype wire

// ===== dv/aesrt_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aesrt_map.vh"

module aesrt_top_tb_top;
  reg          clk_sys = 1'b0;
  reg          rst_b   = 1'b0;
  reg          cv      = 1'b0;
  reg  [2:0]   co      = 3'h0;
  reg          cs      = 1'b0;
  reg  [127:0] cd      = 128'h0;
  reg  [3:0]   dly     = 4'h0;
  wire         rdy, done, lreq, lval, mis;
  wire [31:0]  laddr, ptr;
  wire [127:0] ldata, st0, st1;
  integer      n_mismatch = 0;
  integer      n_checks   = 0;
  integer      cyc        = 0;
  reg  [127:0] v;

  always #5 clk_sys = ~clk_sys;

  aesrt_top i_aesrt_top
  (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .CMD_VALID(cv), .CMD_READY(rdy), .CMD_OP(co),
    .CMD_SEL(cs), .CMD_DATA(cd), .DONE(done), .LOAD_REQ(lreq),
    .LOAD_VIRTUAL_ADDRESS(laddr), .LOAD_DATA_IN(ldata), .LOAD_VALID(lval),
    .STATE0(st0), .STATE1(st1), .POINTER(ptr), .MISALIGNED(mis)
  );

  aesrt_load_model i_aesrt_load_model
  (
    .clk(clk_sys), .load_req(lreq), .addr(laddr), .dly(dly), .valid(lval), .data(ldata)
  );

  function [7:0] gfd(input [7:0] b);
    gfd = {b[6:0], 1'b0} ^ (b[7] ? 8'h1b : 8'h00);
  endfunction

  function [127:0] mixref(input [127:0] s);
    integer   c;
    reg [7:0] a0, a1, a2, a3;
    for (c = 0; c < 4; c = c + 1)
    begin
      a0 = s[127-32*c -: 8];
      a1 = s[119-32*c -: 8];
      a2 = s[111-32*c -: 8];
      a3 = s[103-32*c -: 8];
      mixref[127-32*c -: 8] = gfd(a0) ^ gfd(a1) ^ a1 ^ a2 ^ a3;
      mixref[119-32*c -: 8] = a0 ^ gfd(a1) ^ gfd(a2) ^ a2 ^ a3;
      mixref[111-32*c -: 8] = a0 ^ a1 ^ gfd(a2) ^ gfd(a3) ^ a3;
      mixref[103-32*c -: 8] = gfd(a0) ^ a0 ^ a1 ^ a2 ^ gfd(a3);
    end
  endfunction

  function [127:0] keyof(input [31:0] a);
    keyof = {a, ~a, a ^ 32'h5a5a5a5a, a + 32'h1};
  endfunction

  task chk(input [127:0] s, input [127:0] e);
    n_checks = n_checks + 1;
    if (s !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // Waits for DONE under a bound, so a lost answer cannot hang the run
  task cmd(input [2:0] op, input sel, input [127:0] d);
    integer k;
    @(posedge clk_sys);
    cv <= 1'b1;
    co <= op;
    cs <= sel;
    cd <= d;
    @(posedge clk_sys);
    cv <= 1'b0;
    #1;
    for (k = 0; k < 20 && done !== 1'b1; k = k + 1)
    begin
      @(posedge clk_sys);
      #1;
    end
    chk(done, 1'b1);
    // Single-cycle ops answer at once; a key op answers the cycle after its word
    if (op != `AESRT_OP_ROUNDKEY)
      chk(k, 0);
    else
      chk(k, dly + 4'h1);
    @(posedge clk_sys);
    #1;
    chk({done, rdy, lreq}, 3'h2);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task t_reset;
    chk(st0, 128'h0);
    chk(st1, 128'h0);
    chk({ptr, rdy, lreq, mis, done}, {32'h0, 4'h8});
  endtask

  task t_subbytes;
    cmd(`AESRT_OP_LOAD, 1'b0, 128'h0);
    cmd(`AESRT_OP_LOAD, 1'b1, 128'h000102030405060708090a0b0c0d0e0f);
    cmd(`AESRT_OP_SUBBYTES, 1'b1, 128'h0);
    chk(st1, 128'h637c777bf26b6fc53001672bfed7ab76);
    chk(st0, 128'h0);
  endtask

  task t_mix;
    v = 128'h80ff017fdb135345c6c6c6c68e4da1bc;
    cmd(`AESRT_OP_LOAD, 1'b0, v);
    cmd(`AESRT_OP_MIXCOL, 1'b0, 128'h0);
    chk(st0, mixref(v));
  endtask

  task t_roundkey;
    v = 128'h00112233445566778899aabbccddeeff;
    cmd(`AESRT_OP_LOAD, 1'b1, v);
    cmd(`AESRT_OP_SETPTR, 1'b0, 128'h200);
    dly <= 4'h3;
    cmd(`AESRT_OP_ROUNDKEY, 1'b1, 128'h0);
    chk(st1, v ^ keyof(32'h200));
    chk(ptr, 32'h210);
    dly <= 4'h0;
    cmd(`AESRT_OP_ROUNDKEY, 1'b1, 128'h0);
    chk(st1, v ^ keyof(32'h200) ^ keyof(32'h210));
    chk(ptr, 32'h220);
    chk(st0, mixref(128'h80ff017fdb135345c6c6c6c68e4da1bc));
  endtask

  task t_misc;
    v = mixref(128'h80ff017fdb135345c6c6c6c68e4da1bc);
    cmd(`AESRT_OP_MOVE, 1'b0, 128'h0);
    chk(st1, v);
    cmd(3'h7, 1'b0, 128'h0);
    chk(st1, v);
    chk(st0, v);
    cmd(`AESRT_OP_SETPTR, 1'b0, 128'h204);
    chk(ptr, 32'h204);
    chk(mis, 1'b1);
  endtask

  // Whole run needs well under 300 cycles
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    #1;
    t_reset;
    @(posedge clk_sys);
    rst_b <= 1'b1;
    t_subbytes;
    t_mix;
    t_roundkey;
    t_misc;
    report_and_stop;
  end
endmodule
`default_nettype wire
